// ### dv/sacr_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "sacr_map.svh"
module sacr_regs_monitor
   import sacr_pkg::*;
(
   // Clock and reset
   input wire logic        clock_i,
   input wire logic        rst_b_i,
   // APB
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [31:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   // Controller side
   input wire logic        tx_active_i,
   input wire logic        tx_pulse_i,
   input wire logic        soft_reset_o,
   input wire logic        host_mode_o,
   input wire logic        command_chain_enable_o,
   input wire logic        line_drive_b_n_o,
   input wire logic        driver_enable_n_o
);
   localparam logic [31:0] A_CFG = {26'h0, `SACR_IDX_CONFIG, 2'b00};
   localparam logic [31:0] A_SEL = {26'h0, `SACR_IDX_SELECT, 2'b00};
   logic nxt_cfg_wr;
   logic cfg_wr_ff;
   always_comb nxt_cfg_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == A_CFG;
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i) cfg_wr_ff <= 1'b0;
      else cfg_wr_ff <= nxt_cfg_wr;
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_sel_rd;
      psel_i && penable_i && pready_o && !pwrite_i && paddr_i == A_SEL;
   endsequence
   a_ready_after_setup: assert property (s_setup |=> pready_o) else $error("pready late");
   a_err_with_ready: assert property (pslverr_o |-> pready_o) else $error("pslverr alone");
   a_sel_upper_zero: assert property (s_sel_rd |-> prdata_o[7:3] == 5'h0)
      else $error("select upper bits set");
   a_soft_rst_set: assert property (nxt_cfg_wr && pwdata_i[7] |=> soft_reset_o)
      else $error("soft reset not entered");
   a_soft_rst_clr: assert property (nxt_cfg_wr && !pwdata_i[7] |=> !soft_reset_o)
      else $error("soft reset not left");
   a_soft_rst_hold: assert property ($fell(soft_reset_o) |-> cfg_wr_ff)
      else $error("soft reset left alone");
   a_host_mode_keep: assert property (soft_reset_o |=> $stable(host_mode_o))
      else $error("host mode changed");
   a_chain_keep: assert property (soft_reset_o && !nxt_cfg_wr |=> $stable(command_chain_enable_o))
      else $error("config changed");
   a_drv_idle: assert property (!tx_active_i || soft_reset_o |=> driver_enable_n_o)
      else $error("driver active");
   a_line_soft: assert property (soft_reset_o |=> line_drive_b_n_o)
      else $error("line active in soft reset");
   a_line_idle: assert property (!tx_pulse_i |=> line_drive_b_n_o)
      else $error("line active");
endmodule : sacr_regs_monitor
bind sacr_regs sacr_regs_monitor u_mon (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_active_i(tx_active_i),
   .tx_pulse_i(tx_pulse_i), .soft_reset_o(soft_reset_o), .host_mode_o(host_mode_o),
   .command_chain_enable_o(command_chain_enable_o), .line_drive_b_n_o(line_drive_b_n_o),
   .driver_enable_n_o(driver_enable_n_o));
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sacr_map.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
   import sacr_pkg::*;
   localparam logic [31:0] A_ST = {26'h0, `SACR_IDX_STATUS, 2'b00};
   localparam logic [31:0] A_DG = {26'h0, `SACR_IDX_DIAG, 2'b00};
   localparam logic [31:0] A_SEL = {26'h0, `SACR_IDX_SELECT, 2'b00};
   localparam logic [31:0] A_CFG = {26'h0, `SACR_IDX_CONFIG, 2'b00};
   localparam logic [31:0] A_IND = {26'h0, `SACR_IDX_INDIRECT, 2'b00};
   localparam logic [32:0] ERR = 33'h1_0000_0000;
   logic clock_i = 0, rst_b_i = 0, psel = 0, penable = 0, pwrite = 0, host_mode = 1;
   logic [31:0] paddr = 0, pwdata = 0, prdata, seed = 32'd51821;
   logic pready, pslverr, load = 0, tx_act = 1, tx_pul = 1, srst, hmode, drv_n, line_n;
   logic [7:0] st_set = 0, dg_set = 0, nid = 0, node_id, v[8];
   logic [7:0] cfg_v;
   logic       chain, et_a, et_b, bpl;
   logic [32:0] exp_q[$], e;
   int num_errors = 0, n_tests = 0;
   always #12.5 clock_i = ~clock_i;
   sacr_regs DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .host_mode_i(host_mode), .status_set_i(st_set),
      .diag_set_i(dg_set), .next_id_load_i(load), .next_id_i(nid), .tx_active_i(tx_act),
      .tx_pulse_i(tx_pul), .soft_reset_o(srst), .host_mode_o(hmode),
      .command_chain_enable_o(chain), .long_timeout_sel_a_o(et_a), .long_timeout_sel_b_o(et_b),
      .backplane_o(bpl), .node_id_o(node_id), .line_drive_b_n_o(line_n),
      .driver_enable_n_o(drv_n));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic apb(input logic w, input logic [31:0] a, d, input logic [32:0] x);
      @(posedge clock_i);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      exp_q.push_back(x);
      @(posedge clock_i);
      penable <= 1;
      do @(posedge clock_i); while (pready !== 1'b1);
      psel <= 0; penable <= 0;
   endtask : apb
   task automatic give_verdict();
      if (exp_q.size() != 0) num_errors++;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict
   // ----------------------------------------
   // Result checker
   // ----------------------------------------
   always @(posedge clock_i)
   begin
      if (psel && penable && pready === 1'b1) begin
         if (exp_q.size() == 0) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, prdata, 0); end
         else begin
            e = exp_q.pop_front();
            `CHK(pslverr, e[32])
            if (!pwrite) `CHK(prdata, e[31:0])
         end
      end
   end
   initial begin #200us; num_errors++; give_verdict(); end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (3) @(posedge clock_i);
      rst_b_i <= 1;
      repeat (3) @(posedge clock_i);
      apb(0, A_CFG, 0, 0);
      `CHK(drv_n, 1'b1)
      apb(1, A_SEL, 32'h0000_00FF, 0);
      apb(0, A_SEL, 0, 33'h07);
      apb(1, A_CFG, 32'h0000_0023, 0);
      apb(0, A_CFG, 0, 33'h23);
      apb(0, A_SEL, 0, 33'h03);
      `CHK({drv_n, line_n}, 2'b00)
      @(posedge clock_i);
      nid <= 8'(rnd()); load <= 1; st_set <= 8'h5A; dg_set <= 8'hC3;
      @(posedge clock_i);
      load <= 0; st_set <= 0; dg_set <= 0;
      for (int i = 0; i < 8; i++) begin
         v[i] = (i == 3) ? nid : (i == 7) ? 8'h00 : 8'(rnd());
         apb(1, A_SEL, i, 0);
         apb(1, A_IND, {rnd() & 32'hFFFF_FF00} | v[i], 0);
         apb(0, A_IND, 0, {25'h0, v[i]});
      end
      `CHK(node_id, v[1])
      apb(0, A_ST, 0, 33'h5A);
      apb(0, A_DG, 0, 33'hC3);
      apb(1, A_CFG, 32'h0000_00A3, 0);
      host_mode <= 0;
      repeat (2) @(negedge clock_i);
      `CHK({srst, hmode, drv_n}, 3'b111)
      apb(0, A_ST, 0, 0);
      apb(0, A_DG, 0, 0);
      apb(0, A_IND, 0, 0);
      apb(0, A_CFG, 0, 33'hA3);
      apb(1, A_SEL, 1, 0);
      apb(0, A_IND, 0, {25'h0, v[1]});
      apb(1, A_CFG, 32'h0000_0021, 0);
      repeat (2) @(negedge clock_i);
      `CHK({srst, hmode, drv_n}, 3'b010)
      @(posedge clock_i);
      tx_act <= 0; tx_pul <= 0;
      repeat (2) @(negedge clock_i);
      `CHK({drv_n, line_n}, 2'b11)
      cfg_v = 8'(rnd()) & 8'h7F;
      apb(1, A_CFG, {24'h00_0000, cfg_v}, 0);
      apb(0, A_CFG, 0, {25'h0, cfg_v});
      `CHK({chain, et_a, et_b, bpl}, {cfg_v[`SACR_CFG_CHAIN], cfg_v[`SACR_CFG_ET_A:`SACR_CFG_BACKPLANE]})
      apb(0, 32'h0000_0040, 0, ERR);
      apb(1, 32'h0000_0044, rnd(), ERR);
      repeat (2) @(posedge clock_i);
      give_verdict();
   end
endmodule : tb
`default_nettype wire

// ### rtl/sacr_map.svh
`ifndef SACR_MAP_SVH
`define SACR_MAP_SVH

// Register indices; byte address is four times the index
`define SACR_IDX_STATUS    4'h0
`define SACR_IDX_DIAG      4'h1
`define SACR_IDX_SELECT    4'h3
`define SACR_IDX_CONFIG    4'h6
`define SACR_IDX_INDIRECT  4'h7

// Configuration register fields
`define SACR_CFG_SOFT_RST  7
`define SACR_CFG_CHAIN     6
`define SACR_CFG_TX_ALLOW  5
`define SACR_CFG_ET_A      4
`define SACR_CFG_ET_B      3
`define SACR_CFG_BACKPLANE 2

// Reset values
`define SACR_CFG_RST       8'h00
`define SACR_SEL_RST       3'h0
`define SACR_IND_RST       8'h00
`define SACR_STATUS_RST    8'h00
`define SACR_DIAG_RST      8'h00
`define SACR_NEXT_ID_RST   8'h00

`endif

// ### rtl/sacr_pkg.sv
package sacr_pkg;

   // Registers reached through the shared indirect location
   typedef enum logic [2:0] {
      SACR_IND_TENT_ID,
      SACR_IND_NODE_ID,
      SACR_IND_SETUP_ONE,
      SACR_IND_NEXT_ID,
      SACR_IND_SETUP_TWO,
      SACR_IND_BUS_CTRL,
      SACR_IND_XFER_CNT,
      SACR_IND_RESERVED
   } sacr_ind_e;

   typedef logic [7:0] sacr_byte_t;

endpackage : sacr_pkg

// ### rtl/sacr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "sacr_map.svh"

// Behaviour
// - A three-bit select code chooses which of tentative id, node id, setup one, next id, setup two, bus control, transfer count or reserved is reached at location 07.
// - Bits 7 to 3 of the select register have no function and read as zero.
// - Writing the configuration register clears the top select bit and loads the two lower select bits from the written value.
// - Writing one to configuration bit 7 enters a software reset that lasts while the bit stays set.
// - The software reset leaves the detected host mode and the configuration register untouched.
// - The software reset reinitialises only the status, next id and diagnostic status registers.
module sacr_regs
   import sacr_pkg::*;
(
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Controller side
   input  wire logic        host_mode_i,
   input  wire logic [7:0]  status_set_i,
   input  wire logic [7:0]  diag_set_i,
   input  wire logic        next_id_load_i,
   input  wire logic [7:0]  next_id_i,
   input  wire logic        tx_active_i,
   input  wire logic        tx_pulse_i,
   // Configuration outputs
   output logic             soft_reset_o,
   output logic             host_mode_o,
   output logic             command_chain_enable_o,
   output logic             long_timeout_sel_a_o,
   output logic             long_timeout_sel_b_o,
   output logic             backplane_o,
   output logic [7:0]       node_id_o,
   // Line driver pins
   output logic             line_drive_b_n_o,
   output logic             driver_enable_n_o
);

   //-------------------------------------------------------------------
   // Reset synchroniser
   //-------------------------------------------------------------------
   logic rst_meta_b_ff;
   logic rst_sync_b_ff;

   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rst_meta_b_ff <= 1'b0;
         rst_sync_b_ff <= 1'b0;
      end
      else
      begin
         rst_meta_b_ff <= 1'b1;
         rst_sync_b_ff <= rst_meta_b_ff;
      end
   end

   //-------------------------------------------------------------------
   // Address decode
   //-------------------------------------------------------------------
   function automatic logic sacr_hit(input logic [31:0] addr, input logic [3:0] idx);
      sacr_hit = (addr[31:6] == 26'h000_0000) && (addr[5:2] == idx) && (addr[1:0] == 2'b00);
   endfunction : sacr_hit

   function automatic logic sacr_mapped(input logic [31:0] addr);
      sacr_mapped = sacr_hit(addr, `SACR_IDX_STATUS) || sacr_hit(addr, `SACR_IDX_DIAG)
                    || sacr_hit(addr, `SACR_IDX_SELECT) || sacr_hit(addr, `SACR_IDX_CONFIG)
                    || sacr_hit(addr, `SACR_IDX_INDIRECT);
   endfunction : sacr_mapped

   //-------------------------------------------------------------------
   // Register state
   //-------------------------------------------------------------------
   sacr_byte_t cfg_ff;
   sacr_byte_t nxt_cfg;
   logic [2:0] sel_ff;
   logic [2:0] nxt_sel;
   sacr_byte_t status_ff;
   sacr_byte_t nxt_status;
   sacr_byte_t diag_ff;
   sacr_byte_t nxt_diag;
   sacr_byte_t ind_ff [0:6];
   sacr_byte_t nxt_ind [0:6];
   logic       mode_ff;
   logic       nxt_mode;
   logic       mode_taken_ff;
   logic       nxt_mode_taken;

   logic       wr_en;
   logic       soft_rst;
   sacr_byte_t wbyte;

   assign wr_en    = psel_i && penable_i && pready_o && pwrite_i;
   assign wbyte    = pwdata_i[7:0];
   assign soft_rst = cfg_ff[`SACR_CFG_SOFT_RST];

   always_comb
   begin
      nxt_cfg        = cfg_ff;
      nxt_sel        = sel_ff;
      nxt_mode       = mode_ff;
      nxt_mode_taken = 1'b1;
      for (int i = 0; i < 7; i++)
      begin
         nxt_ind[i] = ind_ff[i];
      end
      // Host mode is caught once after release and never touched again
      if (!mode_taken_ff)
      begin
         nxt_mode = host_mode_i;
      end
      // Configuration write also reloads the low select bits
      if (wr_en && sacr_hit(paddr_i, `SACR_IDX_CONFIG))
      begin
         nxt_cfg = wbyte;
         nxt_sel = {1'b0, wbyte[1:0]};
      end
      if (wr_en && sacr_hit(paddr_i, `SACR_IDX_SELECT))
      begin
         nxt_sel = wbyte[2:0];
      end
      // Indirect write lands in the register the select code names, except next id and reserved, which ignore it
      if (wr_en && sacr_hit(paddr_i, `SACR_IDX_INDIRECT))
      begin
         case (sacr_ind_e'(sel_ff))
            SACR_IND_NEXT_ID  : ;
            SACR_IND_RESERVED : ;
            default           : nxt_ind[sel_ff] = wbyte;
         endcase
      end
      if (next_id_load_i)
      begin
         nxt_ind[SACR_IND_NEXT_ID] = next_id_i;
      end
      // Software reset: only status, next id and diagnostics return
      if (soft_rst)
      begin
         nxt_ind[SACR_IND_NEXT_ID] = `SACR_NEXT_ID_RST;
      end
   end

   //-------------------------------------------------------------------
   // Sticky status and diagnostics, write one to clear, set wins
   //-------------------------------------------------------------------
   always_comb
   begin
      nxt_status = status_ff | status_set_i;
      nxt_diag   = diag_ff | diag_set_i;
      if (wr_en && sacr_hit(paddr_i, `SACR_IDX_STATUS))
      begin
         nxt_status = (status_ff & ~wbyte) | status_set_i;
      end
      if (wr_en && sacr_hit(paddr_i, `SACR_IDX_DIAG))
      begin
         nxt_diag = (diag_ff & ~wbyte) | diag_set_i;
      end
      if (soft_rst)
      begin
         nxt_status = `SACR_STATUS_RST;
         nxt_diag   = `SACR_DIAG_RST;
      end
   end

   always_ff @(posedge clock_i or negedge rst_sync_b_ff)
   begin
      if (!rst_sync_b_ff)
      begin
         cfg_ff        <= `SACR_CFG_RST;
         sel_ff        <= `SACR_SEL_RST;
         status_ff     <= `SACR_STATUS_RST;
         diag_ff       <= `SACR_DIAG_RST;
         mode_ff       <= 1'b0;
         mode_taken_ff <= 1'b0;
      end
      else
      begin
         cfg_ff        <= nxt_cfg;
         sel_ff        <= nxt_sel;
         status_ff     <= nxt_status;
         diag_ff       <= nxt_diag;
         mode_ff       <= nxt_mode;
         mode_taken_ff <= nxt_mode_taken;
      end
   end

   generate
      for (genvar g = 0; g < 7; g++)
      begin : g_ind
         always_ff @(posedge clock_i or negedge rst_sync_b_ff)
         begin
            if (!rst_sync_b_ff)
            begin
               ind_ff[g] <= `SACR_IND_RST;
            end
            else
            begin
               ind_ff[g] <= nxt_ind[g];
            end
         end
      end
   endgenerate

   //-------------------------------------------------------------------
   // APB answer: no wait state, read data registered
   //-------------------------------------------------------------------
   logic        pready_ff;
   logic        nxt_pready;
   logic        pslverr_ff;
   logic        nxt_pslverr;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   sacr_byte_t  rd_byte;

   always_comb
   begin
      rd_byte = 8'h00;
      if (sacr_hit(paddr_i, `SACR_IDX_STATUS))
      begin
         rd_byte = status_ff;
      end
      else if (sacr_hit(paddr_i, `SACR_IDX_DIAG))
      begin
         rd_byte = diag_ff;
      end
      else if (sacr_hit(paddr_i, `SACR_IDX_SELECT))
      begin
         rd_byte = {5'b0_0000, sel_ff};
      end
      else if (sacr_hit(paddr_i, `SACR_IDX_CONFIG))
      begin
         rd_byte = {cfg_ff[7:2], sel_ff[1:0]};
      end
      else if (sacr_hit(paddr_i, `SACR_IDX_INDIRECT))
      begin
         case (sacr_ind_e'(sel_ff))
            SACR_IND_RESERVED : rd_byte = 8'h00;
            default           : rd_byte = ind_ff[sel_ff];
         endcase
      end
      nxt_pready  = psel_i && !penable_i;
      nxt_pslverr = psel_i && !penable_i && !sacr_mapped(paddr_i);
      nxt_prdata  = prdata_ff;
      if (psel_i && !penable_i)
      begin
         nxt_prdata = {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge clock_i or negedge rst_sync_b_ff)
   begin
      if (!rst_sync_b_ff)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end
      else
      begin
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         prdata_ff  <= nxt_prdata;
      end
   end

   assign pready_o  = pready_ff;
   assign pslverr_o = pslverr_ff;
   assign prdata_o  = prdata_ff;

   //-------------------------------------------------------------------
   // Line driver gating
   //-------------------------------------------------------------------
   logic line_n_ff;
   logic nxt_line_n;
   logic drv_n_ff;
   logic nxt_drv_n;

   always_comb
   begin
      nxt_line_n = 1'b1;
      nxt_drv_n  = 1'b1;
      // Drivers stay off while transmit is not allowed or in soft reset
      if (cfg_ff[`SACR_CFG_TX_ALLOW] && !soft_rst)
      begin
         nxt_drv_n  = !tx_active_i;
         nxt_line_n = !(tx_active_i && tx_pulse_i && !cfg_ff[`SACR_CFG_BACKPLANE]);
      end
   end

   always_ff @(posedge clock_i or negedge rst_sync_b_ff)
   begin
      if (!rst_sync_b_ff)
      begin
         line_n_ff <= 1'b1;
         drv_n_ff  <= 1'b1;
      end
      else
      begin
         line_n_ff <= nxt_line_n;
         drv_n_ff  <= nxt_drv_n;
      end
   end

   assign line_drive_b_n_o       = line_n_ff;
   assign driver_enable_n_o      = drv_n_ff;
   assign soft_reset_o           = cfg_ff[`SACR_CFG_SOFT_RST];
   assign host_mode_o            = mode_ff;
   assign command_chain_enable_o = cfg_ff[`SACR_CFG_CHAIN];
   assign long_timeout_sel_a_o   = cfg_ff[`SACR_CFG_ET_A];
   assign long_timeout_sel_b_o   = cfg_ff[`SACR_CFG_ET_B];
   assign backplane_o            = cfg_ff[`SACR_CFG_BACKPLANE];
   assign node_id_o              = ind_ff[SACR_IND_NODE_ID];

endmodule : sacr_regs
`default_nettype wire
